//--- verilog/port_change_cfg.svh
`ifndef PORT_CHANGE_CFG_SVH
`define PORT_CHANGE_CFG_SVH

// Register byte offsets
`define OFS_PORT_STATUS   8'h00
`define OFS_PORT_CONFIG   8'h04
`define OFS_IRQ_STATUS    8'h08
`define OFS_IRQ_MASK      8'h0c

// Port status, lower word: read status, write commands
`define BIT_CURRENT_CONNECT  0
`define BIT_PORT_ENABLED     1
`define BIT_PORT_SUSPENDED   2
`define BIT_PORT_OVERCURRENT 3
`define BIT_PORT_RESETTING   4
`define CMD_CLEAR_ENABLE     0
`define CMD_SET_ENABLE       1
`define CMD_SET_SUSPEND      2
`define CMD_CLEAR_SUSPEND    3
`define CMD_SET_RESET        4

// Port status, upper word: change flags
`define BIT_CONNECT_CHANGE   16
`define BIT_ENABLE_CHANGE    17
`define BIT_SUSPEND_CHANGE   18
`define BIT_OC_CHANGE        19
`define BIT_RESET_CHANGE     20
`define CHANGE_LSB           16
`define CHANGE_MSB           20

// Configuration register fields
`define BIT_PER_PORT_OC      0
`define BIT_NON_REMOVABLE    1

// Reset values
`define RESET_CHANGE_FLAGS   5'h00
`define RESET_PORT_CONFIG    2'h0
`define RESET_IRQ_MASK       5'h00

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

// Timing, clock at 20 MHz
`define CLK_PERIOD_NS        50
`define RESET_TIME_NS        10000000
`define RESUME_TIME_NS       20000000
`define RESYNC_TIME_NS       3000000
`define CYCLES_MIN(t)        (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verilog/port_change_pkg.sv
package port_change_pkg;

  // Port signalling sequencer
  typedef enum logic [2:0]
  {
    SEQ_IDLE   = 3'b000,
    SEQ_RESET  = 3'b001,
    SEQ_RESUME = 3'b010,
    SEQ_EOP    = 3'b011,
    SEQ_RESYNC = 3'b100
  } seq_state_t;

endpackage

//--- verilog/port_timer.sv
`timescale 1ns/10ps

module port_timer
  #(parameter int WIDTH = 20)
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  // Status
  output logic                  running,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             done_q;
  logic             done_d;

  // Down counter: done pulses count cycles after the load edge
  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (load)
      cnt_d = count;
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1})
        done_d = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign running = (cnt_q != '0);
  assign done    = done_q;

endmodule

//--- verilog/root_port_change_flags.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "port_change_cfg.svh"

// Contract
// - The reset-done change flag (bit 20) is set when the 10 ms port reset drive ends.
// - Writing one to a change flag clears it and writing zero leaves it as it was.
// - The overcurrent change flag reports nothing unless overcurrent is reported per port.
// - The overcurrent change flag is set whenever the port overcurrent flag changes value while overcurrent is reported per port.
// - The suspend change flag (bit 18) is set only after 20 ms resume, an EOP and 3 ms resync.
// - Setting the reset-done change flag also clears the suspend change flag.
// - The enable change flag (bit 17) is set when hardware clears the port-enabled bit.
// - A driver write that changes port-enabled never sets the enable change flag.
// - The connect change flag (bit 16) is set on every attach or detach event while the non-removable mark is clear.
// - Set-reset, set-enable or set-suspend on a disconnected port sets the connect change flag.
// - A port status command write arriving during a transaction takes effect when it completes; change-flag clears act at once.
// - With the non-removable mark, connect change is set only by a root hub reset with a device attached or by a command to a disconnected port.
module root_port_change_flags
  import port_change_pkg::*;
  #(parameter int RESET_CYCLES  = `CYCLES_MIN(`RESET_TIME_NS),
    parameter int RESUME_CYCLES = `CYCLES_MIN(`RESUME_TIME_NS),
    parameter int RESYNC_CYCLES = `CYCLES_MIN(`RESYNC_TIME_NS),
    parameter int TIMER_WIDTH   = 20)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Downstream port events
  input  wire logic        device_attached,
  input  wire logic        overcurrent_in,
  input  wire logic        hw_disable,
  input  wire logic        remote_wake,
  input  wire logic        eop_done,
  input  wire logic        xfer_busy,
  input  wire logic        hub_reset,
  // Port drive
  output logic             port_reset_drive,
  output logic             resume_drive,
  output logic             eop_request,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      `OFS_PORT_STATUS: reg_sel = 3'h1;
      `OFS_PORT_CONFIG: reg_sel = 3'h2;
      `OFS_IRQ_STATUS:  reg_sel = 3'h3;
      `OFS_IRQ_MASK:    reg_sel = 3'h4;
      default:          reg_sel = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI write path: address and data caught in either order
  logic        aw_full_q, aw_full_d;
  logic        w_full_q, w_full_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        wr_fire;
  logic [2:0]  wr_sel;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel        = reg_sel(aw_addr_q);

  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wr_sel == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Decoded write strobes; commands in lane 0, change flags in lane 2
  logic       wr_status, wr_config, wr_irq_stat, wr_irq_mask;
  logic [4:0] cmd_wr;
  logic [4:0] flag_clr;
  assign wr_status   = wr_fire && (wr_sel == 3'h1);
  assign wr_config   = wr_fire && (wr_sel == 3'h2) && w_strb_q[0];
  assign wr_irq_stat = wr_fire && (wr_sel == 3'h3) && w_strb_q[0];
  assign wr_irq_mask = wr_fire && (wr_sel == 3'h4) && w_strb_q[0];
  assign cmd_wr      = (wr_status && w_strb_q[0]) ? w_data_q[4:0] : 5'h00;
  assign flag_clr    = (wr_status && w_strb_q[2])
                       ? w_data_q[`CHANGE_MSB:`CHANGE_LSB] : 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Port state, pending commands, change flags and interrupt registers
  seq_state_t seq_q, seq_d;
  logic [4:0] pend_q, pend_d;
  logic [4:0] chg_q, chg_d;
  logic [4:0] irq_stat_q, irq_stat_d;
  logic [4:0] irq_mask_q, irq_mask_d;
  logic [1:0] cfg_q, cfg_d;
  logic       conn_q, conn_d;
  logic       en_q, en_d;
  logic       susp_q, susp_d;
  logic       oc_q, oc_d;
  logic [4:0] chg_set;
  logic [4:0] cmd_now;
  logic       tmr_load;
  logic [TIMER_WIDTH-1:0] tmr_count;
  logic       tmr_running;
  logic       tmr_done;

  // Shared timer paces reset, resume and resync phases
  port_timer #(.WIDTH(TIMER_WIDTH)) u_timer
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (tmr_load),
    .count   (tmr_count),
    .running (tmr_running),
    .done    (tmr_done)
  );

  // Commands are held back while a transaction is on the wire
  assign cmd_now = xfer_busy ? 5'h00 : (pend_q | cmd_wr);

  always_comb
  begin
    seq_d      = seq_q;
    pend_d     = xfer_busy ? (pend_q | cmd_wr) : 5'h00;
    cfg_d      = wr_config ? w_data_q[1:0] : cfg_q;
    irq_mask_d = wr_irq_mask ? w_data_q[4:0] : irq_mask_q;
    conn_d     = device_attached;
    en_d       = en_q;
    susp_d     = susp_q;
    oc_d       = cfg_q[`BIT_PER_PORT_OC] ? overcurrent_in : 1'b0;
    tmr_load   = 1'b0;
    tmr_count  = '0;
    chg_set    = 5'h00;

    // Attach and detach, or the announce after hub reset when non-removable
    if (cfg_q[`BIT_NON_REMOVABLE])
      chg_set[0] = hub_reset && device_attached;
    else
      chg_set[0] = (device_attached != conn_q);

    // Driver commands; a disconnected port only flags a connect change
    if (cmd_now[`CMD_SET_RESET] || cmd_now[`CMD_SET_ENABLE] || cmd_now[`CMD_SET_SUSPEND])
    begin
      if (!conn_q)
        chg_set[0] = 1'b1;
    end
    if (conn_q)
    begin
      // Driver enable changes never raise the enable change flag
      if (cmd_now[`CMD_SET_ENABLE])
        en_d = 1'b1;
      if (cmd_now[`CMD_CLEAR_ENABLE])
        en_d = 1'b0;
      if (cmd_now[`CMD_SET_SUSPEND] && en_q)
        susp_d = 1'b1;
    end

    // Hardware disable or detach of an enabled port
    if (en_q && (hw_disable || !device_attached))
    begin
      en_d       = 1'b0;
      chg_set[1] = 1'b1;
    end

    // Overcurrent flag edges, only when reported per port
    chg_set[3] = cfg_q[`BIT_PER_PORT_OC] && (oc_d != oc_q);

    unique case (seq_q)
      SEQ_IDLE:
      begin
        if (conn_q && cmd_now[`CMD_SET_RESET])
        begin
          seq_d     = SEQ_RESET;
          tmr_load  = 1'b1;
          tmr_count = TIMER_WIDTH'(RESET_CYCLES);
        end
        else if (susp_q && (cmd_now[`CMD_CLEAR_SUSPEND] || remote_wake))
        begin
          seq_d     = SEQ_RESUME;
          tmr_load  = 1'b1;
          tmr_count = TIMER_WIDTH'(RESUME_CYCLES);
        end
      end
      SEQ_RESET:
        if (tmr_done)
        begin
          seq_d      = SEQ_IDLE;
          en_d       = 1'b1;
          susp_d     = 1'b0;
          chg_set[4] = 1'b1;
        end
      SEQ_RESUME:
        if (tmr_done)
          seq_d = SEQ_EOP;
      SEQ_EOP:
        if (eop_done)
        begin
          seq_d     = SEQ_RESYNC;
          tmr_load  = 1'b1;
          tmr_count = TIMER_WIDTH'(RESYNC_CYCLES);
        end
      SEQ_RESYNC:
        if (tmr_done)
        begin
          seq_d      = SEQ_IDLE;
          susp_d     = 1'b0;
          chg_set[2] = 1'b1;
        end
      default:
        seq_d = SEQ_IDLE;
    endcase

    // Set wins over a one-write clear; reset-done knocks out suspend change
    chg_d = (chg_q & ~flag_clr) | chg_set;
    if (chg_set[4])
      chg_d[2] = 1'b0;
    if (!cfg_q[`BIT_PER_PORT_OC])
      chg_d[3] = 1'b0;

    // Interrupt status: sticky, write one to clear, new events win
    irq_stat_d = (irq_stat_q & ~(wr_irq_stat ? w_data_q[4:0] : 5'h00)) | chg_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_q      <= SEQ_IDLE;
      pend_q     <= 5'h00;
      chg_q      <= `RESET_CHANGE_FLAGS;
      irq_stat_q <= 5'h00;
      irq_mask_q <= `RESET_IRQ_MASK;
      cfg_q      <= `RESET_PORT_CONFIG;
      conn_q     <= 1'b0;
      en_q       <= 1'b0;
      susp_q     <= 1'b0;
      oc_q       <= 1'b0;
    end
    else
    begin
      seq_q      <= seq_d;
      pend_q     <= pend_d;
      chg_q      <= chg_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      cfg_q      <= cfg_d;
      conn_q     <= conn_d;
      en_q       <= en_d;
      susp_q     <= susp_d;
      oc_q       <= oc_d;
    end
  end

  assign port_reset_drive = (seq_q == SEQ_RESET);
  assign resume_drive     = (seq_q == SEQ_RESUME);
  assign eop_request      = (seq_q == SEQ_EOP);
  assign irq              = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // AXI read path: one outstanding read, data registered
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] status_word;

  // Bits 31 to 21 read as zero
  assign status_word = {11'h000, chg_q, 11'h000, seq_q == SEQ_RESET, oc_q, susp_q, en_q, conn_q};
  assign s_axi_arready = !rvalid_q;

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        3'h1: rdata_d = status_word;
        3'h2: rdata_d = {30'h0000_0000, cfg_q};
        3'h3: rdata_d = {27'h000_0000, irq_stat_q};
        3'h4: rdata_d = {27'h000_0000, irq_mask_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_done_set: assert property ((seq_q == SEQ_RESET) && tmr_done |=> chg_q[4])
    else $error("reset-done change not set at end of reset drive");
  a_flag_w1c: assert property (flag_clr[0] && !chg_set[0] |=> !chg_q[0])
    else $error("connect change not cleared by one write");
  a_flag_hold: assert property (chg_q[1] && !flag_clr[1] |=> chg_q[1])
    else $error("enable change lost without a one write");
  a_oc_gated: assert property (!cfg_q[`BIT_PER_PORT_OC] |=> !chg_q[3])
    else $error("overcurrent change raised in global mode");
  a_oc_follow: assert property (cfg_q[`BIT_PER_PORT_OC] && $changed(oc_q) |-> chg_q[3])
    else $error("overcurrent change missed");
  a_resume_seq: assert property ($rose(chg_q[2]) |-> $past(seq_q) == SEQ_RESYNC)
    else $error("suspend change set outside resync end");
  a_reset_kills_susp: assert property (chg_set[4] |=> !chg_q[2])
    else $error("suspend change survived reset done");
  a_hw_disable: assert property (en_q && hw_disable && seq_q == SEQ_IDLE
    |=> !en_q && chg_q[1])
    else $error("hardware disable did not flag");
  a_drv_disable: assert property (en_q && cmd_now[`CMD_CLEAR_ENABLE] && !hw_disable
    && device_attached && !chg_q[1] |=> !chg_q[1])
    else $error("driver disable raised enable change");
  a_dead_cmd: assert property (!conn_q && cmd_now[`CMD_SET_RESET]
    |=> chg_q[0] && seq_q == SEQ_IDLE)
    else $error("command on detached port not flagged");
  a_busy_hold: assert property (xfer_busy && seq_q == SEQ_IDLE |=> seq_q != SEQ_RESET)
    else $error("reset started during a transaction");

endmodule

//--- tb/port_model.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Downstream port: answers an EOP request with a one-cycle done pulse
module port_model
  #(parameter int EOP_DELAY = 5)
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // EOP handshake
  input  wire logic eop_request,
  output logic      eop_done
);
  int wait_q;

  // A slow line on purpose, so an early flag cannot hide behind an instant EOP
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !eop_request)
    begin
      wait_q   <= 0;
      eop_done <= 1'b0;
    end
    else
    begin
      wait_q   <= wait_q + 1;
      eop_done <= (wait_q == EOP_DELAY);
    end
  end
endmodule

//--- tb/test_root_port_change_flags.sv
`timescale 1ns/10ps
`include "port_change_cfg.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module test_root_port_change_flags;
  import port_change_pkg::*;
  localparam int RST_C = 20;
  localparam int RSM_C = 40;
  localparam int RSY_C = 6;
  localparam logic [7:0] PS = `OFS_PORT_STATUS;
  localparam logic [7:0] CF = `OFS_PORT_CONFIG;

  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic device_attached = 0, overcurrent_in = 0, hw_disable = 0, remote_wake = 0;
  logic xfer_busy = 0, hub_reset = 0, eop_done, eop_request, irq;
  logic rst_drv, rsm_drv;
  int   num_errors = 0, num_checks = 0, cyc = 0, el;
  logic a, c, prv, ex;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and cycle count
  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc++;

  root_port_change_flags #(.RESET_CYCLES(RST_C), .RESUME_CYCLES(RSM_C),
    .RESYNC_CYCLES(RSY_C)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .device_attached(device_attached),
    .overcurrent_in(overcurrent_in), .hw_disable(hw_disable), .remote_wake(remote_wake),
    .eop_done(eop_done), .xfer_busy(xfer_busy), .hub_reset(hub_reset),
    .port_reset_drive(rst_drv), .resume_drive(rsm_drv), .eop_request(eop_request),
    .irq(irq));

  port_model i_port (.aclk(aclk), .aresetn(aresetn), .eop_request(eop_request),
    .eop_done(eop_done));

  ////////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    close_out();
  endtask

  // Flag after one-to-clear write, set taking effect before the clear
  function automatic logic w1c(input logic old, input logic set, input logic clr);
    return (old | set) & ~clr;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: starts one edge in, so no signal is assigned twice in a time step
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= ad;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    if (n >= 50) hang();
    bready <= 1'b0;
    `CHK(bresp, er);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    if (n >= 50) hang();
    d = rdata;
    rready <= 1'b0;
    `CHK(rresp, er);
  endtask

  task automatic expect_bits(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(ad, d, `RESP_OKAY);
    `CHK(d & m, e);
  endtask

  // Polls a status bit by register reads, returning the cycles taken
  task automatic poll(input int b, output int t);
    logic [31:0] d;
    int st, n;
    st = cyc;
    n = 0;
    do
    begin
      rd(PS, d, `RESP_OKAY);
      n++;
    end
    while (!d[b] && n < 100);
    if (n >= 100) hang();
    t = cyc - st;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic clr_flags();
    wr(PS, 32'h001f_0000, 4'h4, `RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] d;
    void'($urandom(45));
    idle(12);
    aresetn <= 1'b1;
    expect_bits(PS, 32'hffff_ffff, 32'h0);
    expect_bits(CF, 32'h3, 32'h0);
    rd(8'h10, d, `RESP_SLVERR);
    `CHK(d, 32'h0);
    // Attach, then zero and one writes to the connect flag
    device_attached <= 1'b1;
    idle(4);
    expect_bits(PS, 32'h0001_0001, 32'h0001_0001);
    wr(PS, 32'h0, 4'hf, `RESP_OKAY);
    expect_bits(PS, 32'h0001_0000, 32'h0001_0000);
    `CHK(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h1f, 4'h1, `RESP_OKAY);
    idle(2);
    `CHK(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h1f, 4'h1, `RESP_OKAY);
    idle(2);
    `CHK(irq, 1'b0);
    clr_flags();
    expect_bits(PS, 32'h0001_0000, 32'h0);
    // Driver enable, then hardware disable
    wr(PS, 32'h2, 4'h1, `RESP_OKAY);
    expect_bits(PS, 32'h0002_0002, 32'h0000_0002);
    hw_disable <= 1'b1;
    @(posedge aclk);
    hw_disable <= 1'b0;
    idle(3);
    expect_bits(PS, 32'h0002_0002, 32'h0002_0000);
    // Suspend, device resume, then port reset
    wr(PS, 32'h2, 4'h1, `RESP_OKAY);
    wr(PS, 32'h4, 4'h1, `RESP_OKAY);
    remote_wake <= 1'b1;
    @(posedge aclk);
    remote_wake <= 1'b0;
    idle(1);
    `CHK(rsm_drv, 1'b1);
    poll(`BIT_SUSPEND_CHANGE, el);
    `CHK(el >= RSM_C + RSY_C, 1'b1);
    wr(PS, 32'h10, 4'h1, `RESP_OKAY);
    `CHK(rst_drv, 1'b1);
    poll(`BIT_RESET_CHANGE, el);
    `CHK(el >= RST_C, 1'b1);
    `CHK(rst_drv, 1'b0);
    expect_bits(PS, 32'h0014_0002, 32'h0010_0002);
    // Suspend again, resume started by the driver's clear-suspend write
    wr(PS, 32'h4, 4'h1, `RESP_OKAY);
    wr(PS, 32'h8, 4'h1, `RESP_OKAY);
    `CHK(rsm_drv, 1'b1);
    poll(`BIT_SUSPEND_CHANGE, el);
    `CHK(el >= RSM_C + RSY_C, 1'b1);
    // Driver disable held back by a transaction on the wire
    clr_flags();
    xfer_busy <= 1'b1;
    wr(PS, 32'h1, 4'h1, `RESP_OKAY);
    expect_bits(PS, 32'h2, 32'h2);
    xfer_busy <= 1'b0;
    idle(3);
    expect_bits(PS, 32'h0002_0002, 32'h0);
    // Overcurrent with and without per-port reporting
    wr(CF, 32'h1, 4'h1, `RESP_OKAY);
    overcurrent_in <= 1'b1;
    idle(4);
    expect_bits(PS, 32'h0008_0000, 32'h0008_0000);
    clr_flags();
    wr(CF, 32'h0, 4'h1, `RESP_OKAY);
    overcurrent_in <= 1'b0;
    idle(4);
    expect_bits(PS, 32'h0008_0000, 32'h0);
    // Random attach and detach with random clears
    clr_flags();
    ex = 1'b0;
    prv = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      a = 1'($urandom);
      c = 1'($urandom);
      @(posedge aclk);
      device_attached <= a;
      idle(4);
      ex = w1c(ex, a != prv, c);
      prv = a;
      wr(PS, {15'h0, c, 16'h0}, 4'h4, `RESP_OKAY);
      expect_bits(PS, 32'h0001_0000, {15'h0, ex, 16'h0});
    end
    // Commands to a disconnected port
    @(posedge aclk);
    device_attached <= 1'b0;
    idle(4);
    for (int i = 1; i <= 4; i++)
    begin
      if (i != 3)
      begin
        clr_flags();
        wr(PS, 32'h1 << i, 4'h1, `RESP_OKAY);
        idle(2);
        expect_bits(PS, 32'h0001_0000, 32'h0001_0000);
      end
    end
    // Non-removable device announced only by hub reset
    idle(RST_C + 4);
    wr(CF, 32'h2, 4'h1, `RESP_OKAY);
    clr_flags();
    device_attached <= 1'b1;
    idle(4);
    expect_bits(PS, 32'h0001_0000, 32'h0);
    hub_reset <= 1'b1;
    @(posedge aclk);
    hub_reset <= 1'b0;
    idle(3);
    expect_bits(PS, 32'h0001_0000, 32'h0001_0000);
    close_out();
  end
endmodule
